// File: core/slsl_top.sv
// Purpose: APB register block for link quick setup and latency reporting.
// Assumes: pclk at 40 MHz; APB3 master; 8-bit sample words only.
// Notes:   Zero-wait-state slave; status is registered from the config.
//
// How it works
// - Quick codes 0x00,0x01,0x40,0x41,0x42 decode to the one-converter L,F,S sets.
// - Quick codes 0x09,0x48,0x49 decode to the two-converter sets with M equal to converters.
// - All sets report high density off, word width 8, resolution 7 to 8 and up to 1 control bit.
// - Lane rate multiple is 10 or 5 for one converter and 20 or 10 for two, by lane count.
// - Total latency is converter latency plus link latency, fixed by mode and link setup.
// - Converter latency is 31, 94, 162, 292 or 548 clocks by filter depth.
// - Full bandwidth link latency is 25,14,7,4,2 over ratios 0.5 to 8.
// - Decimate-1 gives 25,14,7 with 4 and 8 unsupported; decimate-2 gives 46,27,14,7.
// - Decimate-4, -8 and -16 give the 88, 172 and 339 latency rows.
// - Link latency depends only on mode and ratio, not on real or complex data.
// - Lane rate is M times 8 times 10/8 times output rate over L.
`timescale 1ns/1ps
module slsl_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             link_enable,
    output logic [9:0]       total_latency,
    output logic             config_ok
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0]  line_rate_band_select;
    logic [7:0]  link_quick_setup;
    logic [7:0]  link_mode_ctrl;
    logic [7:0]  link_control;
    logic [7:0]  multiframe_size;
    logic [7:0]  next_line_rate_band_select;
    logic [7:0]  next_link_quick_setup;
    logic [7:0]  next_link_mode_ctrl;
    logic [7:0]  next_link_control;
    logic [7:0]  next_multiframe_size;
    logic [31:0] next_prdata;

    logic        wr_en;
    logic [11:0] word_idx;
    logic        addr_hit;
    logic        link_down;

    assign word_idx  = paddr[13:2];
    assign wr_en     = psel && penable && pwrite;
    assign pready    = 1'b1;
    assign link_down = link_control[slsl_pkg::CTRL_PDN_BIT];

    // ----------------------------------------------------------------
    // Decoders
    // ----------------------------------------------------------------
    logic        code_valid;
    logic [1:0]  lanes;
    logic [1:0]  converters;
    logic [4:0]  octets;
    logic [3:0]  samples;
    logic [4:0]  rate_mult;
    logic [2:0]  ratio_idx;
    logic [9:0]  conv_latency;
    logic [9:0]  link_latency;
    logic        mode_valid;
    logic        k_valid;
    logic [5:0]  k_val;
    logic [5:0]  k_min;

    slsl_link_table u_link (
        .quick_code (link_quick_setup),
        .code_valid (code_valid),
        .lanes      (lanes),
        .converters (converters),
        .octets     (octets),
        .samples    (samples),
        .rate_mult  (rate_mult),
        .ratio_idx  (ratio_idx)
    );

    slsl_latency_table u_lat (
        .dec_mode     (link_mode_ctrl[slsl_pkg::MODE_DEC_LSB +: 3]),
        .complex_out  (link_mode_ctrl[slsl_pkg::MODE_CPLX_BIT]),
        .ratio_idx    (ratio_idx),
        .conv_latency (conv_latency),
        .link_latency (link_latency),
        .mode_valid   (mode_valid)
    );

    // ----------------------------------------------------------------
    // Multiframe check
    // ----------------------------------------------------------------
    always_comb begin
        k_val = multiframe_size[5:0];
        case (octets)
            5'h01:   k_min = slsl_pkg::K_MIN_F1;
            5'h02:   k_min = slsl_pkg::K_MIN_F2;
            5'h04:   k_min = slsl_pkg::K_MIN_F4;
            5'h08:   k_min = slsl_pkg::K_MIN_F8;
            5'h10:   k_min = slsl_pkg::K_MIN_F8;
            default: k_min = slsl_pkg::K_MAX;
        endcase
        k_valid = (k_val[1:0] == 2'b00) && (k_val >= k_min) && (k_val <= slsl_pkg::K_MAX);
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_comb begin
        next_line_rate_band_select = line_rate_band_select;
        next_link_quick_setup      = link_quick_setup;
        next_link_mode_ctrl        = link_mode_ctrl;
        next_link_control          = link_control;
        next_multiframe_size       = multiframe_size;
        if (wr_en) begin
            case (word_idx)
                slsl_pkg::IDX_LINE_RATE_BAND_SELECT: next_line_rate_band_select = pwdata[7:0];
                slsl_pkg::IDX_LINK_QUICK_SETUP:      next_link_quick_setup      = pwdata[7:0];
                slsl_pkg::IDX_LINK_MODE_CTRL:        next_link_mode_ctrl        = {3'h0, pwdata[4:0]};
                slsl_pkg::IDX_LINK_CONTROL:          next_link_control          = {6'h00, pwdata[1:0]};
                slsl_pkg::IDX_MULTIFRAME_SIZE:       next_multiframe_size       = {2'h0, pwdata[5:0]};
                default: begin
                    next_link_control = link_control;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read mux and error answer
    // ----------------------------------------------------------------
    always_comb begin
        addr_hit    = 1'b1;
        next_prdata = 32'h0000_0000;
        case (word_idx)
            slsl_pkg::IDX_LINE_RATE_BAND_SELECT: next_prdata = {24'h0, line_rate_band_select};
            slsl_pkg::IDX_LINK_QUICK_SETUP:      next_prdata = {24'h0, link_quick_setup};
            slsl_pkg::IDX_LINK_MODE_CTRL:        next_prdata = {24'h0, link_mode_ctrl};
            slsl_pkg::IDX_LINK_CONTROL:          next_prdata = {24'h0, link_control};
            slsl_pkg::IDX_MULTIFRAME_SIZE:       next_prdata = {24'h0, multiframe_size};
            // Transport fields fixed for 8-bit words
            // Narrow slices keep the status word at 32 bits
            slsl_pkg::IDX_LINK_PARAMS_STATUS: next_prdata = {
                slsl_pkg::HD_VALUE, slsl_pkg::CS_MAX[0], slsl_pkg::RES_MAX[3:0],
                slsl_pkg::RES_MIN[3:0], slsl_pkg::SAMPLE_WORD_WIDTH, rate_mult,
                samples, octets[3:0], converters, lanes};
            slsl_pkg::IDX_LINK_LATENCY_STATUS: next_prdata = {
                k_valid, mode_valid, code_valid, 9'h000,
                link_latency, conv_latency};
            default: begin
                addr_hit    = 1'b0;
                next_prdata = 32'h0000_0000;
            end
        endcase
    end

    // Configuration registers load on the edge that ends the access phase; reset loads the package defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_rate_band_select <= slsl_pkg::RST_LINE_RATE_BAND;
            link_quick_setup      <= slsl_pkg::RST_QUICK_SETUP;
            link_mode_ctrl        <= slsl_pkg::RST_MODE_CTRL;
            link_control          <= slsl_pkg::RST_LINK_CONTROL;
            multiframe_size       <= slsl_pkg::RST_MULTIFRAME;
        end else begin
            line_rate_band_select <= next_line_rate_band_select;
            link_quick_setup      <= next_link_quick_setup;
            link_mode_ctrl        <= next_link_mode_ctrl;
            link_control          <= next_link_control;
            multiframe_size       <= next_multiframe_size;
        end
    end

    // ----------------------------------------------------------------
    // Read data path
    // ----------------------------------------------------------------
    logic [31:0] rd_word;
    logic [31:0] next_rd_word;

    // Read word formed combinationally in the setup cycle, held for access
    always_comb begin
        next_rd_word = rd_word;
        if (psel && !penable && !pwrite) begin
            next_rd_word = next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_word <= 32'h0000_0000;
        end else begin
            rd_word <= next_rd_word;
        end
    end

    // ----------------------------------------------------------------
    // Bus answer and status outputs
    // ----------------------------------------------------------------
    logic [9:0] next_total_latency;
    logic       next_config_ok;
    logic       next_link_enable;

    always_comb begin
        next_total_latency = 10'(conv_latency + link_latency);
        next_config_ok     = code_valid && mode_valid && k_valid;
        // Link only runs while powered up and configured
        next_link_enable   = !link_down && next_config_ok;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total_latency <= 10'h000;
            config_ok     <= 1'b0;
            link_enable   <= 1'b0;
        end else begin
            total_latency <= next_total_latency;
            config_ok     <= next_config_ok;
            link_enable   <= next_link_enable;
        end
    end

    // Read data stand from a flop; error is decoded in the access phase
    assign prdata = rd_word;

    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            pslverr = !addr_hit;
        end
    end

endmodule

// File: core/slsl_pkg.sv
// Purpose: Shared constants for the serial link setup and latency block.
// Assumes: APB byte addressing, 32-bit data, control registers in the low byte.
// Notes:   Offsets are indices; byte address is four times the index.
package slsl_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] IDX_LINE_RATE_BAND_SELECT = 12'h56E;
    localparam logic [11:0] IDX_LINK_QUICK_SETUP      = 12'h570;
    localparam logic [11:0] IDX_LINK_MODE_CTRL        = 12'h571;
    localparam logic [11:0] IDX_LINK_PARAMS_STATUS    = 12'h572;
    localparam logic [11:0] IDX_LINK_LATENCY_STATUS   = 12'h573;
    localparam logic [11:0] IDX_LINK_CONTROL          = 12'h574;
    localparam logic [11:0] IDX_MULTIFRAME_SIZE       = 12'h575;

    localparam logic [7:0] RST_LINE_RATE_BAND = 8'h00;
    localparam logic [7:0] RST_QUICK_SETUP    = 8'h00;
    localparam logic [7:0] RST_MODE_CTRL      = 8'h00;
    localparam logic [7:0] RST_LINK_CONTROL   = 8'h00;
    localparam logic [7:0] RST_MULTIFRAME     = 8'h20;

    // Mode control fields
    localparam int MODE_DEC_LSB = 0;
    localparam int MODE_CPLX_BIT = 4;
    // Link control fields
    localparam int CTRL_PDN_BIT = 0;
    localparam int CTRL_CS_BIT  = 1;

    // ----------------------------------------------------------------
    // Decimation settings
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SLSL_DEC_FULL = 3'h0,
        SLSL_DEC_1    = 3'h1,
        SLSL_DEC_2    = 3'h2,
        SLSL_DEC_4    = 3'h3,
        SLSL_DEC_8    = 3'h4,
        SLSL_DEC_16   = 3'h5
    } slsl_dec_t;

    // Ratio M/L index: 0.5,1,2,4,8
    localparam int RATIO_COUNT = 5;

    // Fixed transport fields for 8-bit words
    localparam logic [4:0] SAMPLE_WORD_WIDTH = 5'h08;
    localparam logic [4:0] RES_MIN           = 5'h07;
    localparam logic [4:0] RES_MAX           = 5'h08;
    localparam logic [1:0] CS_MAX            = 2'h1;
    localparam logic       HD_VALUE          = 1'b0;

    // Lane rate multiples of output rate
    localparam logic [4:0] RATE_M1_L1 = 5'h0A;
    localparam logic [4:0] RATE_M1_L2 = 5'h05;
    localparam logic [4:0] RATE_M2_L1 = 5'h14;
    localparam logic [4:0] RATE_M2_L2 = 5'h0A;

    // Converter plus filter latency
    localparam logic [9:0] LAT_CONV_FULL = 10'h01F;
    localparam logic [9:0] LAT_CONV_D1   = 10'h05E;
    localparam logic [9:0] LAT_CONV_D2   = 10'h0A2;
    localparam logic [9:0] LAT_CONV_D4   = 10'h124;
    localparam logic [9:0] LAT_CONV_D8   = 10'h224;

    // Multiframe bounds
    localparam logic [5:0] K_MAX = 6'h20;
    localparam logic [5:0] K_MIN_F1 = 6'h14;
    localparam logic [5:0] K_MIN_F2 = 6'h0C;
    localparam logic [5:0] K_MIN_F4 = 6'h08;
    localparam logic [5:0] K_MIN_F8 = 6'h04;

endpackage

// File: core/slsl_link_table.sv
// Purpose: Decode a quick code into link parameters.
// Assumes: 8-bit sample words only.
// Notes:   Unknown codes flag invalid and return zero fields.
`timescale 1ns/1ps
module slsl_link_table (
    input  wire logic [7:0] quick_code,
    output logic            code_valid,
    output logic [1:0]      lanes,
    output logic [1:0]      converters,
    output logic [4:0]      octets,
    output logic [3:0]      samples,
    output logic [4:0]      rate_mult,
    output logic [2:0]      ratio_idx
);

    always_comb begin
        code_valid = 1'b1;
        lanes      = 2'h0;
        converters = 2'h0;
        octets     = 5'h00;
        samples    = 4'h0;
        case (quick_code)
            8'h00: begin lanes = 2'h1; converters = 2'h1; octets = 5'h01; samples = 4'h1; end
            8'h01: begin lanes = 2'h1; converters = 2'h1; octets = 5'h02; samples = 4'h2; end
            8'h40: begin lanes = 2'h2; converters = 2'h1; octets = 5'h01; samples = 4'h2; end
            8'h41: begin lanes = 2'h2; converters = 2'h1; octets = 5'h02; samples = 4'h4; end
            8'h42: begin lanes = 2'h2; converters = 2'h1; octets = 5'h04; samples = 4'h8; end
            8'h09: begin lanes = 2'h1; converters = 2'h2; octets = 5'h02; samples = 4'h1; end
            8'h48: begin lanes = 2'h2; converters = 2'h2; octets = 5'h01; samples = 4'h1; end
            8'h49: begin lanes = 2'h2; converters = 2'h2; octets = 5'h02; samples = 4'h2; end
            default: begin
                code_valid = 1'b0;
            end
        endcase
    end

    // Lane rate multiple and M/L ratio follow from M and L
    always_comb begin
        rate_mult = 5'h00;
        ratio_idx = 3'h0;
        case ({converters, lanes})
            4'b0101: begin rate_mult = slsl_pkg::RATE_M1_L1; ratio_idx = 3'h1; end
            4'b0110: begin rate_mult = slsl_pkg::RATE_M1_L2; ratio_idx = 3'h0; end
            4'b1001: begin rate_mult = slsl_pkg::RATE_M2_L1; ratio_idx = 3'h2; end
            4'b1010: begin rate_mult = slsl_pkg::RATE_M2_L2; ratio_idx = 3'h1; end
            default: begin
                rate_mult = 5'h00;
                ratio_idx = 3'h0;
            end
        endcase
    end

endmodule

// File: core/slsl_latency_table.sv
// Purpose: Latency lookup for converter and link stages.
// Assumes: Ratio index 0..4 stands for M/L of 0.5,1,2,4,8.
// Notes:   Unsupported pairs flag invalid and return zero link latency.
`timescale 1ns/1ps
module slsl_latency_table (
    input  wire logic [2:0] dec_mode,
    input  wire logic       complex_out,
    input  wire logic [2:0] ratio_idx,
    output logic [9:0]      conv_latency,
    output logic [9:0]      link_latency,
    output logic            mode_valid
);

    // Real dec-N and complex dec-2N share filters
    logic [2:0] filt;

    always_comb begin
        filt = dec_mode;
        if (complex_out && dec_mode != 3'h0) begin
            filt = dec_mode - 3'h1;
        end
        case (filt)
            3'h0:    conv_latency = (dec_mode == 3'h0) ? slsl_pkg::LAT_CONV_FULL : 10'h000;
            3'h1:    conv_latency = slsl_pkg::LAT_CONV_D1;
            3'h2:    conv_latency = slsl_pkg::LAT_CONV_D2;
            3'h3:    conv_latency = slsl_pkg::LAT_CONV_D4;
            3'h4:    conv_latency = slsl_pkg::LAT_CONV_D8;
            default: conv_latency = 10'h000;
        endcase
    end

    // Output data type takes no part here
    always_comb begin
        link_latency = 10'h000;
        case ({dec_mode, ratio_idx})
            {3'h0, 3'h0}: link_latency = 10'h019;
            {3'h0, 3'h1}: link_latency = 10'h00E;
            {3'h0, 3'h2}: link_latency = 10'h007;
            {3'h0, 3'h3}: link_latency = 10'h004;
            {3'h0, 3'h4}: link_latency = 10'h002;
            {3'h1, 3'h0}: link_latency = 10'h019;
            {3'h1, 3'h1}: link_latency = 10'h00E;
            {3'h1, 3'h2}: link_latency = 10'h007;
            {3'h2, 3'h0}: link_latency = 10'h02E;
            {3'h2, 3'h1}: link_latency = 10'h01B;
            {3'h2, 3'h2}: link_latency = 10'h00E;
            {3'h2, 3'h3}: link_latency = 10'h007;
            {3'h3, 3'h0}: link_latency = 10'h058;
            {3'h3, 3'h1}: link_latency = 10'h032;
            {3'h3, 3'h2}: link_latency = 10'h01B;
            {3'h3, 3'h3}: link_latency = 10'h00E;
            {3'h3, 3'h4}: link_latency = 10'h007;
            {3'h4, 3'h0}: link_latency = 10'h0AC;
            {3'h4, 3'h1}: link_latency = 10'h060;
            {3'h4, 3'h2}: link_latency = 10'h032;
            {3'h4, 3'h3}: link_latency = 10'h01B;
            {3'h4, 3'h4}: link_latency = 10'h00E;
            {3'h5, 3'h0}: link_latency = 10'h153;
            {3'h5, 3'h1}: link_latency = 10'h0BC;
            {3'h5, 3'h2}: link_latency = 10'h060;
            {3'h5, 3'h3}: link_latency = 10'h032;
            {3'h5, 3'h4}: link_latency = 10'h01B;
            default:      link_latency = 10'h000;
        endcase
        mode_valid = (link_latency != 10'h000) && (conv_latency != 10'h000);
    end

endmodule

// File: verif/slsl_top_sva.sv
// Purpose: Port-level checks of the link setup block.
// Assumes: Zero-wait APB slave, active-low async reset.
// Notes:   Addresses are four times the register index.
`timescale 1ns/1ps
module slsl_top_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        link_enable,
    input wire logic [9:0]  total_latency,
    input wire logic        config_ok
);
    localparam logic [15:0] A_CTRL = {2'b00, slsl_pkg::IDX_LINK_CONTROL, 2'b00};
    localparam logic [15:0] A_QS   = {2'b00, slsl_pkg::IDX_LINK_QUICK_SETUP, 2'b00};
    logic       acc;
    logic       ctrl_wr;
    logic       known;
    logic [7:0] qs;
    logic [7:0] next_qs;
    assign acc     = psel && penable;
    assign ctrl_wr = acc && pwrite && (paddr == A_CTRL);
    assign known   = qs inside {8'h00, 8'h01, 8'h40, 8'h41, 8'h42, 8'h09, 8'h48, 8'h49};
    always_comb next_qs = (acc && pwrite && (paddr == A_QS)) ? pwdata[7:0] : qs;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) qs <= slsl_pkg::RST_QUICK_SETUP;
        else qs <= next_qs;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_idle3;
        (!(acc && pwrite))[*3];
    endsequence
    sequence s_bad3;
        (!known)[*3];
    endsequence
    a_ready_high: assert property (psel |-> pready) else $error("pready low");
    a_latency_steady: assert property (s_idle3 |=> $stable(total_latency)) else $error("latency moved");
    a_latency_span: assert property (config_ok |-> total_latency inside {[10'h021:10'h377]})
        else $error("latency out of range");
    a_link_down: assert property (ctrl_wr && pwdata[0] |-> ##[1:3] !link_enable) else $error("no power down");
    a_link_up: assert property (ctrl_wr && !pwdata[0] && config_ok |-> ##[1:3] link_enable)
        else $error("no power up");
    a_enable_cause: assert property ($changed(link_enable) |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $changed(config_ok))
        else $error("enable moved alone");
    a_quick_read: assert property (acc && !pwrite && paddr == A_QS |-> prdata[7:0] == qs)
        else $error("quick code readback");
    a_bad_code: assert property (s_bad3 |-> !config_ok) else $error("bad code accepted");
endmodule
bind slsl_top slsl_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_enable(link_enable), .total_latency(total_latency), .config_ok(config_ok));

// File: verif/slsl_rx_model.sv
// Purpose: Receiver side that latches the reported latency.
// Assumes: Latency is only changed while the link is down.
// Notes:   A change while the link is up would break alignment.
`timescale 1ns/1ps
module slsl_rx_model (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       link_enable,
    input wire logic       config_ok,
    input wire logic [9:0] total_latency,
    output logic [9:0]     seen_latency,
    output logic           drift
);
    logic [9:0] next_seen;
    logic       next_drift;
    logic       was_up;
    always_comb begin
        next_seen  = (link_enable && config_ok) ? total_latency : seen_latency;
        next_drift = drift || (was_up && link_enable && total_latency != seen_latency);
    end
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) {seen_latency, drift, was_up} <= 12'h000;
        else {seen_latency, drift, was_up} <= {next_seen, next_drift, link_enable && config_ok};
endmodule

// File: verif/tb_slsl_top.sv
// Purpose: Self-checking bench for the link setup block.
// Assumes: 40 MHz pclk, zero-wait APB slave.
// Notes:   Every reconfiguration powers the link down first.
`timescale 1ns/1ps
module tb_slsl_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        link_enable;
    logic        config_ok;
    logic        drift;
    logic [9:0]  total_latency;
    logic [9:0]  seen_latency;
    int          num_errors;
    int          compares;
    // Code, mode, K, ok, expected latency
    localparam logic [47:0] ROWS [21] = '{48'h00002001002D, 48'h400020010038, 48'h090020010026,
        48'h410120010077, 48'h481220010079, 48'h0102200100BD, 48'h4213200100FA, 48'h490320010156,
        48'h091420010156, 48'h000420010284, 48'h4815200102E0, 48'h000010000000, 48'h00001401002D,
        48'h000016000000, 48'h01000C01002D, 48'h420008010038, 48'h420004000000, 48'h020020000000,
        48'h001120000000, 48'h000520000000, 48'h000024000000};
    localparam logic [11:0] RIDX [5] = '{12'h56E, 12'h570, 12'h571, 12'h574, 12'h575};
    localparam logic [7:0]  RVAL [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    slsl_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_enable(link_enable), .total_latency(total_latency), .config_ok(config_ok));
    slsl_rx_model rx (.pclk(pclk), .presetn(presetn), .link_enable(link_enable), .config_ok(config_ok),
        .total_latency(total_latency), .seen_latency(seen_latency), .drift(drift));
    task conclude;
        $display("checks %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            conclude();
        end
    endtask
    task cfg(input logic [7:0] code, input logic [7:0] mode, input logic [7:0] k);
        apb(1'b1, 12'h574, 8'h01);
        apb(1'b1, 12'h570, code);
        apb(1'b1, 12'h571, mode);
        apb(1'b1, 12'h575, k);
        apb(1'b1, 12'h574, 8'h00);
        repeat (4) @(posedge pclk);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 52'h0;
        num_errors = 0;
        compares = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, RIDX[i], 8'h00);
            chk("reset value", rd[7:0], RVAL[i]);
        end
        chk("link_enable", link_enable, 1'b1);
        $display("reset test done");
        for (int i = 0; i < 21; i++) begin
            cfg(ROWS[i][47:40], ROWS[i][39:32], ROWS[i][31:24]);
            chk("config_ok", config_ok, ROWS[i][16]);
            if (ROWS[i][16]) chk("total_latency", total_latency, ROWS[i][9:0]);
            if (ROWS[i][16]) chk("seen_latency", seen_latency, ROWS[i][9:0]);
        end
        $display("table test done");
        apb(1'b1, 12'h56E, 8'h30);
        apb(1'b0, 12'h56E, 8'h00);
        chk("band", rd[7:0], 8'h30);
        cfg(8'h41, 8'h00, 8'h20);
        apb(1'b1, 12'h7FF, 8'h42);
        chk("pslverr", err, 1'b1);
        apb(1'b0, 12'h570, 8'h00);
        chk("quick code", rd[7:0], 8'h41);
        chk("pslverr", err, 1'b0);
        apb(1'b0, 12'h572, 8'h00);
        chk("link params", rd, 32'h61D0_5426);
        apb(1'b0, 12'h573, 8'h00);
        chk("latency status", rd, 32'hE000_641F);
        chk("total_latency", total_latency, 10'h038);
        apb(1'b1, 12'h574, 8'h01);
        repeat (3) @(posedge pclk);
        chk("link_enable", link_enable, 1'b0);
        apb(1'b1, 12'h574, 8'h00);
        repeat (3) @(posedge pclk);
        chk("link_enable", link_enable, 1'b1);
        chk("drift", drift, 1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h570, 8'h00);
        chk("quick code", rd[7:0], 8'h00);
        chk("link_enable", link_enable, 1'b1);
        $display("edge test done");
        conclude();
    end
endmodule
